// ### rtl/pdc_regs_pkg.sv
// Contract
// - Receive current address is a full 32-bit word naming where received data is written.
// - Receive current count sits in bits 15..0; upper bits reserved; loaded with buffer size.
// - Transmit current address is 32 bits naming where outgoing data is read.
// - Transmit current count sits in bits 15..0; upper bits reserved; loaded with buffer size.
// - Receive following address is a 32-bit read-write word for the next receive buffer.
// - Receive following count is a 16-bit read-write field for the next receive buffer.
// - Transmit following address is a 32-bit read-write word for the next transmit buffer.
// - Transmit following count is a 16-bit read-write field for the next transmit buffer.
// - Zero receive current count means no receive data is moved.
// - Zero transmit current count means no transmit data is moved.
// - Nonzero current count starts transfers only while that channel is enabled.
// - Half duplex: receive and transmit current addresses are one register.
// - Half duplex: receive and transmit current counts are one shared counter.
// - Half duplex: receive and transmit following addresses are one register.
// - Half duplex: receive and transmit following counts are one register.
// - Current count at zero with nonzero following: copy following to current, clear following.
// - Each unit moved advances the address by one, two or four bytes per size.
// - End flag when current count zero; full/empty flag when current and following zero. Flags set on drain only; full duplex: tx count writes clear rx full.
// - Rewriting an address mid-transfer makes the transfer continue from the new address.
package pdc_regs_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_RX_CUR_ADDR  = 12'h0100;
  localparam logic [11:0] OFS_RX_CUR_CNT   = 12'h0104;
  localparam logic [11:0] OFS_TX_CUR_ADDR  = 12'h0108;
  localparam logic [11:0] OFS_TX_CUR_CNT   = 12'h010C;
  localparam logic [11:0] OFS_RX_FOL_ADDR  = 12'h0110;
  localparam logic [11:0] OFS_RX_FOL_CNT   = 12'h0114;
  localparam logic [11:0] OFS_TX_FOL_ADDR  = 12'h0118;
  localparam logic [11:0] OFS_TX_FOL_CNT   = 12'h011C;
  localparam logic [11:0] OFS_XFER_CTRL    = 12'h0120;
  localparam logic [11:0] OFS_XFER_STAT    = 12'h0124;
  localparam logic [11:0] OFS_FLAGS        = 12'h0128;
  // transfer control / status bit positions
  localparam int BIT_RX_EN  = 0;
  localparam int BIT_RX_DIS = 1;
  localparam int BIT_TX_EN  = 8;
  localparam int BIT_TX_DIS = 9;
  // flag register bit positions
  localparam int BIT_RX_END  = 0;
  localparam int BIT_TX_END  = 1;
  localparam int BIT_RX_FULL = 2;
  localparam int BIT_TX_EMPT = 3;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  // unit size codes and AXI responses
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### rtl/addr_stepper.sv
// one direction's address/count pair update: hold, step, or reload from following set
module addr_stepper (
  // current values
  input  wire logic [31:0] curAddr,
  input  wire logic [15:0] curCnt,
  // following values
  input  wire logic [31:0] folAddr,
  input  wire logic [15:0] folCnt,
  // step request
  input  wire logic        step,
  input  wire logic [1:0]  unitSize,
  // results
  output logic      [31:0] next_curAddr,
  output logic      [15:0] next_curCnt,
  output logic             reload,
  output logic             hitZero
);
  logic [31:0] inc;

  // byte increment per unit size
  always_comb begin
    case (unitSize)
      pdc_regs_pkg::SIZE_BYTE: inc = 32'h0000_0001;
      pdc_regs_pkg::SIZE_HALF: inc = 32'h0000_0002;
      default:                 inc = 32'h0000_0004;
    endcase
  end

  // step decrements, and a drained count takes the following set over
  always_comb begin
    next_curAddr = curAddr;
    next_curCnt  = curCnt;
    reload       = 1'b0;
    hitZero      = 1'b0;
    if (step && curCnt != pdc_regs_pkg::CNT_ZERO) begin
      next_curAddr = curAddr + inc;
      next_curCnt  = curCnt - pdc_regs_pkg::CNT_ONE;
      hitZero      = (next_curCnt == pdc_regs_pkg::CNT_ZERO);
    end
    if (next_curCnt == pdc_regs_pkg::CNT_ZERO && folCnt != pdc_regs_pkg::CNT_ZERO) begin
      next_curAddr = folAddr;
      next_curCnt  = folCnt;
      reload       = 1'b1;
    end
  end
endmodule // addr_stepper

// ### rtl/axil_slave_port.sv
// AXI4-Lite handshake front end: captures one write and one read, presents them as pulses
module axil_slave_port (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // write address / data
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read address / data
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // register side
  output logic             wrStb,
  output logic [11:0]      wrAddr,
  output logic [31:0]      wrData,
  output logic [3:0]       wrStrb,
  input  wire logic        wrOk,
  output logic             rdStb,
  output logic [11:0]      rdAddr,
  input  wire logic [31:0] rdWord,
  input  wire logic        rdOk
);
  logic haveAw;
  logic haveW;

  // a channel is ready only until its half of the write has been caught
  assign awready = !haveAw && !bvalid;
  assign wready  = !haveW && !bvalid;
  assign arready = !rvalid && !rdStb;
  assign wrStb   = haveAw && haveW && !bvalid;

  // write capture, either order
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      haveAw <= 1'b0;
      haveW  <= 1'b0;
      wrAddr <= 12'h000;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        haveAw <= 1'b1;
        wrAddr <= awaddr;
      end
      if (wvalid && wready) begin
        haveW  <= 1'b1;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (wrStb) begin
        haveAw <= 1'b0;
        haveW  <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp  <= pdc_regs_pkg::RESP_OKAY;
    end else if (wrStb) begin
      bvalid <= 1'b1;
      bresp  <= wrOk ? pdc_regs_pkg::RESP_OKAY : pdc_regs_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read: address taken, data one cycle later from the register side
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdStb  <= 1'b0;
      rdAddr <= 12'h000;
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= pdc_regs_pkg::RESP_OKAY;
    end else begin
      rdStb <= arvalid && arready;
      if (arvalid && arready) rdAddr <= araddr;
      if (rdStb) begin
        rvalid <= 1'b1;
        rdata  <= rdWord;
        rresp  <= rdOk ? pdc_regs_pkg::RESP_OKAY : pdc_regs_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // axil_slave_port

// ### rtl/periph_dma_channel.sv
// pointer/counter registers of one peripheral DMA channel pair, with a simple unit strobe interface
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
module periph_dma_channel #(
  parameter bit HALF_DUPLEX = 1'b0
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // AXI4-Lite write
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // transfer unit size for both directions
  input  wire logic [1:0]  unitSize,
  // receive side: peripheral has data, engine asks, bus matrix completes a unit
  input  wire logic        rxReady,
  output logic             rxRequest,
  output logic [31:0]      rxMemAddr,
  input  wire logic        rxUnitDone,
  // transmit side
  input  wire logic        txReady,
  output logic             txRequest,
  output logic [31:0]      txMemAddr,
  input  wire logic        txUnitDone,
  // flags toward the peripheral status register
  output logic             rx_end_flag,
  output logic             tx_end_flag,
  output logic             rx_buffers_full_flag,
  output logic             tx_buffers_empty_flag,
  output logic             rxEnabled,
  output logic             txEnabled
);
  logic        wrStb;
  logic [11:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic        wrOk;
  logic        rdStb;
  logic [11:0] rdAddr;
  logic [31:0] rdWord;
  logic        rdOk;

  logic [31:0] rxCurAddr;
  logic [15:0] rxCurCnt;
  logic [31:0] rxFolAddr;
  logic [15:0] rxFolCnt;
  logic [31:0] txCurAddr;
  logic [15:0] txCurCnt;
  logic [31:0] txFolAddr;
  logic [15:0] txFolCnt;

  logic [31:0] rxStepAddr;
  logic [15:0] rxStepCnt;
  logic        rxReload;
  logic        rxHitZero;
  logic [31:0] txStepAddr;
  logic [15:0] txStepCnt;
  logic        txReload;
  logic        txHitZero;

  logic [31:0] wMask;
  logic [31:0] merged;

  // bus handshake front end
  axil_slave_port busPort (
    .ref_clk (ref_clk),
    .rst     (rst),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wrStb   (wrStb),
    .wrAddr  (wrAddr),
    .wrData  (wrData),
    .wrStrb  (wrStrb),
    .wrOk    (wrOk),
    .rdStb   (rdStb),
    .rdAddr  (rdAddr),
    .rdWord  (rdWord),
    .rdOk    (rdOk)
  );

  // the shared store steps from whichever direction is active in half duplex
  logic txStepSel;
  assign txStepSel = HALF_DUPLEX && txEnabled;

  // receive and transmit step/reload arithmetic
  addr_stepper rxStep (
    .curAddr      (rxCurAddr),
    .curCnt       (rxCurCnt),
    .folAddr      (rxFolAddr),
    .folCnt       (rxFolCnt),
    .step         (txStepSel ? txUnitDone : rxUnitDone),
    .unitSize     (unitSize),
    .next_curAddr (rxStepAddr),
    .next_curCnt  (rxStepCnt),
    .reload       (rxReload),
    .hitZero      (rxHitZero)
  );

  addr_stepper txStep (
    .curAddr      (txCurAddr),
    .curCnt       (txCurCnt),
    .folAddr      (txFolAddr),
    .folCnt       (txFolCnt),
    .step         (txUnitDone),
    .unitSize     (unitSize),
    .next_curAddr (txStepAddr),
    .next_curCnt  (txStepCnt),
    .reload       (txReload),
    .hitZero      (txHitZero)
  );

  // byte-lane mask from write strobes
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gLane
      assign wMask[g*8 +: 8] = {8{wrStrb[g]}};
    end
  endgenerate

  function automatic logic [31:0] mergeWord(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [31:0] msk);
    mergeWord = (old & ~msk) | (nw & msk);
  endfunction

  // write decode flags
  logic wRxCA;
  logic wRxCC;
  logic wTxCA;
  logic wTxCC;
  logic wRxFA;
  logic wRxFC;
  logic wTxFA;
  logic wTxFC;
  logic wCtrl;
  always_comb begin
    wRxCA = wrStb && wrAddr == pdc_regs_pkg::OFS_RX_CUR_ADDR;
    wRxCC = wrStb && wrAddr == pdc_regs_pkg::OFS_RX_CUR_CNT;
    wTxCA = wrStb && wrAddr == pdc_regs_pkg::OFS_TX_CUR_ADDR;
    wTxCC = wrStb && wrAddr == pdc_regs_pkg::OFS_TX_CUR_CNT;
    wRxFA = wrStb && wrAddr == pdc_regs_pkg::OFS_RX_FOL_ADDR;
    wRxFC = wrStb && wrAddr == pdc_regs_pkg::OFS_RX_FOL_CNT;
    wTxFA = wrStb && wrAddr == pdc_regs_pkg::OFS_TX_FOL_ADDR;
    wTxFC = wrStb && wrAddr == pdc_regs_pkg::OFS_TX_FOL_CNT;
    wCtrl = wrStb && wrAddr == pdc_regs_pkg::OFS_XFER_CTRL;
    wrOk  = wRxCA || wRxCC || wTxCA || wTxCC || wRxFA || wRxFC || wTxFA || wTxFC || wCtrl;
  end

  // half duplex folds writes to either name into one store; the tx copy is then unused
  logic hdAnyCA;
  logic hdAnyCC;
  logic hdAnyFA;
  logic hdAnyFC;
  assign hdAnyCA = HALF_DUPLEX ? (wRxCA || wTxCA) : wRxCA;
  assign hdAnyCC = HALF_DUPLEX ? (wRxCC || wTxCC) : wRxCC;
  assign hdAnyFA = HALF_DUPLEX ? (wRxFA || wTxFA) : wRxFA;
  assign hdAnyFC = HALF_DUPLEX ? (wRxFC || wTxFC) : wRxFC;
  assign merged  = wrData;

  // receive (or shared half duplex) set; software writes win over a step in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxCurAddr <= pdc_regs_pkg::RESET_WORD;
      rxCurCnt  <= pdc_regs_pkg::CNT_ZERO;
      rxFolAddr <= pdc_regs_pkg::RESET_WORD;
      rxFolCnt  <= pdc_regs_pkg::CNT_ZERO;
    end else begin
      rxCurAddr <= hdAnyCA ? mergeWord(rxCurAddr, merged, wMask) : rxStepAddr;
      rxCurCnt  <= hdAnyCC ? 16'(mergeWord({16'h0000, rxCurCnt}, merged, wMask))
                           : rxStepCnt;
      if (hdAnyFA) rxFolAddr <= mergeWord(rxFolAddr, merged, wMask);
      else if (rxReload) rxFolAddr <= pdc_regs_pkg::RESET_WORD;
      if (hdAnyFC) rxFolCnt <= 16'(mergeWord({16'h0000, rxFolCnt}, merged, wMask));
      else if (rxReload) rxFolCnt <= pdc_regs_pkg::CNT_ZERO;
    end
  end

  // transmit set (full duplex only)
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txCurAddr <= pdc_regs_pkg::RESET_WORD;
      txCurCnt  <= pdc_regs_pkg::CNT_ZERO;
      txFolAddr <= pdc_regs_pkg::RESET_WORD;
      txFolCnt  <= pdc_regs_pkg::CNT_ZERO;
    end else begin
      txCurAddr <= wTxCA ? mergeWord(txCurAddr, merged, wMask) : txStepAddr;
      txCurCnt  <= wTxCC ? 16'(mergeWord({16'h0000, txCurCnt}, merged, wMask)) : txStepCnt;
      if (wTxFA) txFolAddr <= mergeWord(txFolAddr, merged, wMask);
      else if (txReload) txFolAddr <= pdc_regs_pkg::RESET_WORD;
      if (wTxFC) txFolCnt <= 16'(mergeWord({16'h0000, txFolCnt}, merged, wMask));
      else if (txReload) txFolCnt <= pdc_regs_pkg::CNT_ZERO;
    end
  end

  // channel enables; half duplex keeps at most one direction on
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxEnabled <= 1'b0;
      txEnabled <= 1'b0;
    end else if (wCtrl) begin
      if (HALF_DUPLEX) begin
        if (wrData[pdc_regs_pkg::BIT_RX_DIS] || wrData[pdc_regs_pkg::BIT_TX_DIS]) begin
          rxEnabled <= 1'b0;
          txEnabled <= 1'b0;
        end else if (wrData[pdc_regs_pkg::BIT_RX_EN]) begin
          rxEnabled <= 1'b1;
          txEnabled <= 1'b0;
        end else if (wrData[pdc_regs_pkg::BIT_TX_EN]) begin
          rxEnabled <= 1'b0;
          txEnabled <= 1'b1;
        end
      end else begin
        if (wrData[pdc_regs_pkg::BIT_RX_DIS]) rxEnabled <= 1'b0;
        else if (wrData[pdc_regs_pkg::BIT_RX_EN]) rxEnabled <= 1'b1;
        if (wrData[pdc_regs_pkg::BIT_TX_DIS]) txEnabled <= 1'b0;
        else if (wrData[pdc_regs_pkg::BIT_TX_EN]) txEnabled <= 1'b1;
      end
    end
  end

  // effective views: half duplex reads the shared store under both names
  logic [31:0] effTxCA;
  logic [15:0] effTxCC;
  logic [31:0] effTxFA;
  logic [15:0] effTxFC;
  assign effTxCA = HALF_DUPLEX ? rxCurAddr : txCurAddr;
  assign effTxCC = HALF_DUPLEX ? rxCurCnt  : txCurCnt;
  assign effTxFA = HALF_DUPLEX ? rxFolAddr : txFolAddr;
  assign effTxFC = HALF_DUPLEX ? rxFolCnt  : txFolCnt;

  // requests only with a live count and an enabled channel
  assign rxRequest = rxReady && rxEnabled && rxCurCnt != pdc_regs_pkg::CNT_ZERO;
  assign txRequest = txReady && txEnabled && effTxCC != pdc_regs_pkg::CNT_ZERO;
  assign rxMemAddr = rxCurAddr;
  assign txMemAddr = effTxCA;

  // flags: set on drain, cleared by a nonzero count write (rx_buffers_full_flag by a transmit count write in full duplex); set wins
  logic rxCntWr;
  logic txCntWr;
  assign rxCntWr = (hdAnyCC || hdAnyFC) && wrData[15:0] != pdc_regs_pkg::CNT_ZERO;
  assign txCntWr = HALF_DUPLEX ? rxCntWr : ((wTxCC || wTxFC) && wrData[15:0] != pdc_regs_pkg::CNT_ZERO);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_end_flag           <= 1'b0;
      tx_end_flag           <= 1'b0;
      rx_buffers_full_flag  <= 1'b0;
      tx_buffers_empty_flag <= 1'b0;
    end else begin
      if (rxHitZero && !txStepSel) rx_end_flag <= 1'b1;
      else if (rxCntWr) rx_end_flag <= 1'b0;
      if (rxHitZero && !rxReload && !txStepSel) rx_buffers_full_flag <= 1'b1;
      else if (txCntWr) rx_buffers_full_flag <= 1'b0;
      if ((HALF_DUPLEX ? (rxHitZero && txStepSel) : txHitZero)) tx_end_flag <= 1'b1;
      else if (txCntWr) tx_end_flag <= 1'b0;
      if ((HALF_DUPLEX ? (rxHitZero && !rxReload && txStepSel) : (txHitZero && !txReload)))
        tx_buffers_empty_flag <= 1'b1;
      else if (txCntWr) tx_buffers_empty_flag <= 1'b0;
    end
  end

  // read mux; counts show units remaining, upper bits zero
  always_comb begin
    rdOk = 1'b1;
    case (rdAddr)
      pdc_regs_pkg::OFS_RX_CUR_ADDR: rdWord = rxCurAddr;
      pdc_regs_pkg::OFS_RX_CUR_CNT:  rdWord = {16'h0000, rxCurCnt};
      pdc_regs_pkg::OFS_TX_CUR_ADDR: rdWord = effTxCA;
      pdc_regs_pkg::OFS_TX_CUR_CNT:  rdWord = {16'h0000, effTxCC};
      pdc_regs_pkg::OFS_RX_FOL_ADDR: rdWord = rxFolAddr;
      pdc_regs_pkg::OFS_RX_FOL_CNT:  rdWord = {16'h0000, rxFolCnt};
      pdc_regs_pkg::OFS_TX_FOL_ADDR: rdWord = effTxFA;
      pdc_regs_pkg::OFS_TX_FOL_CNT:  rdWord = {16'h0000, effTxFC};
      pdc_regs_pkg::OFS_XFER_CTRL:   rdWord = pdc_regs_pkg::RESET_WORD; // write-only
      pdc_regs_pkg::OFS_XFER_STAT: begin
        rdWord = pdc_regs_pkg::RESET_WORD;
        rdWord[pdc_regs_pkg::BIT_RX_EN] = rxEnabled;
        rdWord[pdc_regs_pkg::BIT_TX_EN] = txEnabled;
      end
      pdc_regs_pkg::OFS_FLAGS: begin
        rdWord = pdc_regs_pkg::RESET_WORD;
        rdWord[pdc_regs_pkg::BIT_RX_END]  = rx_end_flag;
        rdWord[pdc_regs_pkg::BIT_TX_END]  = tx_end_flag;
        rdWord[pdc_regs_pkg::BIT_RX_FULL] = rx_buffers_full_flag;
        rdWord[pdc_regs_pkg::BIT_TX_EMPT] = tx_buffers_empty_flag;
      end
      default: begin
        rdWord = pdc_regs_pkg::RESET_WORD;
        rdOk   = 1'b0;
      end
    endcase
  end
endmodule // periph_dma_channel

// ### sim/pdc_regs_chk.sv
module pdc_regs_chk (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // bus handshakes
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  // data side
  input wire logic [1:0]  unitSize,
  input wire logic        rxReady,
  input wire logic        rxRequest,
  input wire logic [31:0] rxMemAddr,
  input wire logic        rxUnitDone,
  input wire logic        rxEnabled,
  input wire logic        txReady,
  input wire logic        txRequest,
  input wire logic        txEnabled,
  input wire logic        rx_end_flag,
  input wire logic        tx_buffers_empty_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // byte step per unit; the spare size code steps like a word
  function automatic logic [31:0] stepOf(input logic [1:0] s);
    return s[1] ? 32'h0000_0004 : (s[0] ? 32'h0000_0002 : 32'h0000_0001);
  endfunction
  a_rx_req_gate: assert property (rxRequest |-> rxReady && rxEnabled)
    else $error("rx request while not ready or not enabled");
  a_tx_req_gate: assert property (txRequest |-> txReady && txEnabled)
    else $error("tx request while not ready or not enabled");
  // a register write commits while awready is low, so it is kept out of the step checks
  a_rx_addr_step: assert property (rxUnitDone && rxRequest && awready |=>
    rxMemAddr == $past(rxMemAddr) + stepOf($past(unitSize))) else $error("rx address step wrong");
  a_rx_addr_hold: assert property (awready && !rxUnitDone |=> $stable(rxMemAddr))
    else $error("rx address moved without a unit");
  a_tx_empty_quiet: assert property ($rose(tx_buffers_empty_flag) |-> !txRequest)
    else $error("tx request with both tx counts at zero");
  a_rx_end_cause: assert property ($rose(rx_end_flag) |-> $past(rxUnitDone))
    else $error("rx end flag without a finishing unit");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  a_write_release: assert property (bvalid && bready |=> !bvalid)
    else $error("write response held after accept");
  a_read_answer: assert property (arvalid && arready |-> ##2 rvalid)
    else $error("read data late");
  c_rx_end: cover property ($rose(rx_end_flag));
  c_tx_empty: cover property ($rose(tx_buffers_empty_flag));
  c_half_step: cover property (rxUnitDone && unitSize == pdc_regs_pkg::SIZE_HALF);
endmodule // pdc_regs_chk

bind periph_dma_channel pdc_regs_chk pdc_regs_chk_i (
  .ref_clk, .rst, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready,
  .rvalid, .unitSize, .rxReady, .rxRequest, .rxMemAddr, .rxUnitDone, .rxEnabled, .txReady,
  .txRequest, .txEnabled, .rx_end_flag, .tx_buffers_empty_flag
);

// ### sim/pdc_partner.sv
module pdc_partner (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // bench controls
  input  wire logic rxGo,
  input  wire logic txGo,
  input  wire logic slow,
  // channel side
  input  wire logic rxRequest,
  input  wire logic txRequest,
  output logic      rxReady,
  output logic      txReady,
  output logic      rxUnitDone,
  output logic      txUnitDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic phase;
  // a unit only completes on a live request; a slow matrix answers on alternate cycles
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {phase, rxReady, txReady, rxUnitDone, txUnitDone} <= '0;
    end else begin
      phase      <= !phase;
      rxReady    <= rxGo;
      txReady    <= txGo;
      rxUnitDone <= rxRequest && !rxUnitDone && (phase || !slow);
      txUnitDone <= txRequest && !txUnitDone && (phase || !slow);
    end
  end
endmodule // pdc_partner

// ### sim/periph_dma_channel_tb_top.sv
module periph_dma_channel_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  unitSize = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, rxGo = 0, txGo = 0, slow = 0;
  wire logic   awready, wready, bvalid, arready, rvalid, rxReady, txReady, rxRequest, txRequest;
  wire logic   rxUnitDone, txUnitDone, rxEnabled, txEnabled, rx_end_flag, tx_end_flag;
  wire logic   rx_buffers_full_flag, tx_buffers_empty_flag;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata, rxMemAddr, txMemAddr;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  int          checked = 0, miscompares = 0;

  always #50 ref_clk = !ref_clk;

  periph_dma_channel #(.HALF_DUPLEX(1'b0)) periph_dma_channel_i (
    .ref_clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .unitSize, .rxReady,
    .rxRequest, .rxMemAddr, .rxUnitDone, .txReady, .txRequest, .txMemAddr, .txUnitDone, .rx_end_flag,
    .tx_end_flag, .rx_buffers_full_flag, .tx_buffers_empty_flag, .rxEnabled, .txEnabled
  );
  pdc_partner pdc_partner_i (
    .ref_clk, .rst, .rxGo, .txGo, .slow, .rxRequest, .txRequest, .rxReady, .txReady, .rxUnitDone,
    .txUnitDone
  );

  task automatic check(input string n, input logic [33:0] s, input logic [33:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // register index 0..7 in map order, one word apart
  function automatic logic [11:0] ofs(input int i);
    return pdc_regs_pkg::OFS_RX_CUR_ADDR + 12'(4 * i);
  endfunction

  // each channel is released at the edge that takes it; the response is awaited without a count
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = pdc_regs_pkg::RESP_OKAY);
    bq.push_back(r);
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1;
    wvalid  <= 1;
    bready  <= 1;
    #1;
    while (awvalid || wvalid) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      #1;
    end
    do @(posedge ref_clk); while (!bvalid);
    bready <= 0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = pdc_regs_pkg::RESP_OKAY);
    rq.push_back({r, d});
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1;
    rready  <= 1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 0;
    do @(posedge ref_clk); while (!rvalid);
    rready <= 0;
  endtask

  // responses are taken at the accepting edge and matched against the oldest note
  always @(posedge ref_clk) begin
    if (bvalid && bready) check("bresp", {32'h0000_0000, bresp}, {32'h0000_0000, bq.pop_front()});
    if (rvalid && rready) check("read", {rresp, rdata}, rq.pop_front());
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end

  initial begin
    logic [31:0] v, a0, b0;
    int n, m;
    v = $urandom(32'h2439);
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    for (int i = 0; i < 8; i++) rd(ofs(i), pdc_regs_pkg::RESET_WORD);
    rd(pdc_regs_pkg::OFS_FLAGS, pdc_regs_pkg::RESET_WORD);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      wr(ofs(i), v);
      rd(ofs(i), i[0] ? {16'h0000, v[15:0]} : v);
    end
    wr(12'h0200, v, pdc_regs_pkg::RESP_SLVERR);
    rd(pdc_regs_pkg::OFS_XFER_CTRL, pdc_regs_pkg::RESET_WORD);
    // receive in every unit size; the first buffer waits on a disabled channel
    wr(ofs(5), 32'h0000_0000);
    rxGo <= 1;
    for (int s = 0; s < 3; s++) begin
      a0 = $urandom;
      n = 1 + $urandom % 6;
      unitSize <= 2'(s);
      slow <= 1'($urandom);
      wr(ofs(0), a0);
      wr(ofs(1), 32'(n));
      if (s == 0) begin
        repeat (10) @(posedge ref_clk);
        rd(ofs(1), 32'(n));
        wr(pdc_regs_pkg::OFS_XFER_CTRL, 32'h0000_0001 << pdc_regs_pkg::BIT_RX_EN);
      end
      for (int k = 0; k < 300 && rx_end_flag !== 1'b1; k++) @(posedge ref_clk);
      rd(ofs(0), a0 + 32'(n << s));
      rd(ofs(1), 32'h0000_0000);
      rd(pdc_regs_pkg::OFS_FLAGS, 32'h0000_0005);
    end
    // transmit two chained buffers in words; the following pair is consumed and cleared
    a0 = $urandom;
    b0 = $urandom;
    n = 1 + $urandom % 4;
    m = 1 + $urandom % 4;
    unitSize <= pdc_regs_pkg::SIZE_WORD;
    txGo <= 1;
    wr(ofs(2), a0);
    wr(ofs(6), b0);
    wr(ofs(7), 32'(m));
    wr(ofs(3), 32'(n));
    wr(pdc_regs_pkg::OFS_XFER_CTRL, 32'h0000_0001 << pdc_regs_pkg::BIT_TX_EN);
    rd(pdc_regs_pkg::OFS_XFER_STAT, 32'h0000_0101);
    for (int k = 0; k < 300 && tx_buffers_empty_flag !== 1'b1; k++) @(posedge ref_clk);
    rd(ofs(2), b0 + 32'(m * 4));
    rd(ofs(3), 32'h0000_0000);
    rd(ofs(6), 32'h0000_0000);
    rd(ofs(7), 32'h0000_0000);
    rd(pdc_regs_pkg::OFS_FLAGS, 32'h0000_000B);
    complete_run();
  end
endmodule // periph_dma_channel_tb_top
